// File: rtl/scrs_cfg.svh
// Constants for the spindle commutator and retract sequencer
`ifndef SCRS_CFG_SVH
`define SCRS_CFG_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCRS_CLK_NS 40
`define SCRS_MS_NS 1000000
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCRS_OFF_CTRL 8'h00
`define SCRS_OFF_LVL1 8'h04
`define SCRS_OFF_LVL2 8'h08
`define SCRS_OFF_BDLY 8'h0c
`define SCRS_OFF_AMP 8'h10
`define SCRS_OFF_STAT 8'h14
`define SCRS_OFF_ISTAT 8'h18
`define SCRS_OFF_IEN 8'h1c
`define SCRS_OFF_ICLR 8'h20
// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define SCRS_B_ENABLE 0
`define SCRS_B_RESET 1
`define SCRS_B_RETRACT 2
`define SCRS_B_STEP 3
`define SCRS_B_PWRDIS 4
// ----------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------
`define SCRS_I_RSTART 0
`define SCRS_I_FLOAT 1
`define SCRS_I_BRAKE 2
`define SCRS_I_SAT 3
`define SCRS_I_FAULT 4
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SCRS_NIRQ 5
`define SCRS_RST_CTRL 5'h00
`define SCRS_RST_DUR 8'h00
`define SCRS_RST_AMP 3'h0
`define SCRS_RST_IRQ 5'h00
`define SCRS_NSYNC 4
`endif

// File: rtl/scrs_pkg.sv
// Types shared by the spindle commutator and retract sequencer
package scrs_pkg;
  // Spindle mode, Gray along preset-start-run-coast-brake
  typedef enum logic [2:0] {
    scrs_preset = 3'h0,
    scrs_start = 3'h1,
    scrs_run = 3'h3,
    scrs_coast = 3'h2,
    scrs_brake = 3'h6
  } scrs_mode_t;
  // Commutator state, Gray along reset-A..F-A
  typedef enum logic [2:0] {
    scrs_com_rst = 3'h0,
    scrs_com_a = 3'h1,
    scrs_com_b = 3'h3,
    scrs_com_c = 3'h2,
    scrs_com_d = 3'h6,
    scrs_com_e = 3'h7,
    scrs_com_f = 3'h5
  } scrs_com_t;
  // Actuator operation, Gray along linear-level1-level2-float
  typedef enum logic [1:0] {
    scrs_act_linear = 2'h0,
    scrs_act_lvl1 = 2'h1,
    scrs_act_lvl2 = 2'h3,
    scrs_act_float = 2'h2
  } scrs_act_t;
endpackage

// File: rtl/scrs_commutator.sv
// Seven-state spindle commutator (reset, then A to F ring) with phase error polarity
`timescale 1ns/1ns
module scrs_commutator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic clear,
  output scrs_pkg::scrs_com_t state,
  output logic [2:0] hi_en,
  output logic [2:0] lo_en,
  output logic sink_on_pos
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Winding drive {hi[2:0], lo[2:0]}, bit0 is winding one
  function automatic logic [5:0] drive_of(scrs_pkg::scrs_com_t s);
    unique case (s)
      scrs_pkg::scrs_com_rst: drive_of = {3'h5, 3'h2};
      scrs_pkg::scrs_com_a: drive_of = {3'h1, 3'h4};
      scrs_pkg::scrs_com_b: drive_of = {3'h2, 3'h4};
      scrs_pkg::scrs_com_c: drive_of = {3'h2, 3'h1};
      scrs_pkg::scrs_com_d: drive_of = {3'h4, 3'h1};
      scrs_pkg::scrs_com_e: drive_of = {3'h4, 3'h2};
      scrs_pkg::scrs_com_f: drive_of = {3'h1, 3'h2};
      default: drive_of = 6'h00;
    endcase
  endfunction
  // Next state in the A to F ring
  function automatic scrs_pkg::scrs_com_t succ(scrs_pkg::scrs_com_t s);
    unique case (s)
      scrs_pkg::scrs_com_a: succ = scrs_pkg::scrs_com_b;
      scrs_pkg::scrs_com_b: succ = scrs_pkg::scrs_com_c;
      scrs_pkg::scrs_com_c: succ = scrs_pkg::scrs_com_d;
      scrs_pkg::scrs_com_d: succ = scrs_pkg::scrs_com_e;
      scrs_pkg::scrs_com_e: succ = scrs_pkg::scrs_com_f;
      default: succ = scrs_pkg::scrs_com_a;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  scrs_pkg::scrs_com_t state_reg; // Present state
  scrs_pkg::scrs_com_t state_next; // Next state
  always_comb begin
    if (clear) begin
      state_next = scrs_pkg::scrs_com_rst;
    end else if (step) begin
      state_next = succ(state_reg);
    end else begin
      state_next = state_reg;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= scrs_pkg::scrs_com_rst;
    end else begin
      state_reg <= state_next;
    end
  end
  // Drive and polarity registered with the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_en <= 3'h5;
      lo_en <= 3'h2;
      sink_on_pos <= 1'b0;
    end else begin
      {hi_en, lo_en} <= drive_of(state_next);
      // Sink states B, D and F
      sink_on_pos <= (state_next == scrs_pkg::scrs_com_b) ||
                     (state_next == scrs_pkg::scrs_com_d) ||
                     (state_next == scrs_pkg::scrs_com_f);
    end
  end
  assign state = state_reg;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == scrs_pkg::scrs_com_f && step && !clear) |=>
      (state_reg == scrs_pkg::scrs_com_a);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("commutator did not wrap from F to A");
  property p_drive;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == scrs_pkg::scrs_com_b) |->
      (hi_en == 3'h2 && lo_en == 3'h4 && sink_on_pos);
  endproperty
  a_drive: assert property (p_drive)
    else $error("state B drive pattern wrong");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      clear |=> (state_reg == scrs_pkg::scrs_com_rst && hi_en == 3'h5);
  endproperty
  a_clear: assert property (p_clear)
    else $error("commutator not reset on clear");
endmodule

// File: rtl/scrs_top.sv
// Actuator retract sequencer and spindle commutator control, APB slave
//
// Overview of operation
// - Fault or host request starts actuator retract
// - Otherwise actuator runs linear
// - Level one for its time, then level two
// - After level two, actuator outputs float
// - Durations and level-two amplitude come from registers
// - Brake spindle after programmed brake delay
// - Run mode: oscillator pulse steps commutator
// - Start mode: each host step pulse steps once
// - Windings driven per commutator state table
// - Undriven winding compared with driven mean
// - Pump polarity per state when undriven positive
// - Flag amplifier saturation during linear operation
// - Pump only in run; else loop node idles
// - Mode decoded from reset, enable, power-disable
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "scrs_cfg.svh"
module scrs_top #(
  parameter int MS_CYCLES = `SCRS_MS_NS / `SCRS_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic voltage_fault,
  input wire logic vco_pulse,
  input wire logic undriven_positive,
  input wire logic amp_saturated,
  output logic [2:0] winding_hi_en,
  output logic [2:0] winding_lo_en,
  output logic pump_source,
  output logic pump_sink,
  output logic loop_filter_idle,
  output logic act_linear,
  output logic act_level_one,
  output logic act_level_two,
  output logic act_float,
  output logic [2:0] level_two_amp,
  output logic spindle_brake,
  output logic sat_flag,
  output logic irq
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`SCRS_NSYNC-1:0] sync1_reg; // First stage, read only below
  logic [`SCRS_NSYNC-1:0] sync2_reg; // Second stage
  logic vco_last_reg; // Previous oscillator level
  logic fault_s, vco_s, upos_s, sat_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      vco_last_reg <= 1'b0;
    end else begin
      sync1_reg <= {amp_saturated, undriven_positive, vco_pulse,
                    voltage_fault};
      sync2_reg <= sync1_reg;
      vco_last_reg <= sync2_reg[1];
    end
  end
  assign fault_s = sync2_reg[0];
  assign vco_s = sync2_reg[1];
  assign upos_s = sync2_reg[2];
  assign sat_s = sync2_reg[3];
  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [4:0] ctrl_reg; // Enable, reset, retract, step, power-disable
  logic [7:0] level_one_duration; // Level one time in ms
  logic [7:0] level_two_duration; // Level two time in ms
  logic [7:0] brake_delay_interval; // Brake delay in ms
  logic [2:0] amp_reg; // Level two amplitude code
  logic [`SCRS_NIRQ-1:0] istat_reg; // Sticky event bits
  logic [`SCRS_NIRQ-1:0] ien_reg; // Event enables
  logic [`SCRS_NIRQ-1:0] iev; // Events this cycle
  logic wr_en, rd_en;
  logic mapped;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable;
  // Address hit test
  function automatic logic hit(logic [7:0] a);
    hit = (a == `SCRS_OFF_CTRL) || (a == `SCRS_OFF_LVL1) ||
          (a == `SCRS_OFF_LVL2) || (a == `SCRS_OFF_BDLY) ||
          (a == `SCRS_OFF_AMP) || (a == `SCRS_OFF_STAT) ||
          (a == `SCRS_OFF_ISTAT) || (a == `SCRS_OFF_IEN) ||
          (a == `SCRS_OFF_ICLR);
  endfunction
  assign mapped = hit(paddr);
  // Writable registers take effect at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SCRS_RST_CTRL;
      level_one_duration <= `SCRS_RST_DUR;
      level_two_duration <= `SCRS_RST_DUR;
      brake_delay_interval <= `SCRS_RST_DUR;
      amp_reg <= `SCRS_RST_AMP;
      ien_reg <= `SCRS_RST_IRQ;
    end else if (wr_en) begin
      unique case (paddr)
        `SCRS_OFF_CTRL: ctrl_reg <= pwdata[4:0];
        `SCRS_OFF_LVL1: level_one_duration <= pwdata[7:0];
        `SCRS_OFF_LVL2: level_two_duration <= pwdata[7:0];
        `SCRS_OFF_BDLY: brake_delay_interval <= pwdata[7:0];
        `SCRS_OFF_AMP: amp_reg <= pwdata[2:0];
        `SCRS_OFF_IEN: ien_reg <= pwdata[`SCRS_NIRQ-1:0];
        default: ;
      endcase
    end
  end
  // Sticky status; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= `SCRS_RST_IRQ;
    end else if (wr_en && paddr == `SCRS_OFF_ICLR) begin
      istat_reg <= (istat_reg & ~pwdata[`SCRS_NIRQ-1:0]) | iev;
    end else begin
      istat_reg <= istat_reg | iev;
    end
  end
  assign irq = |(istat_reg & ien_reg);
  // ----------------------------------------------------------------
  // Mode decode and commutator
  // ----------------------------------------------------------------
  scrs_pkg::scrs_mode_t mode; // Decoded spindle mode
  logic host_retract_request, manual_step_bit, power_disable_bit;
  logic step_last_reg; // Previous step bit
  logic com_step, com_clear, sink_on_pos;
  scrs_pkg::scrs_com_t com_state;
  assign host_retract_request = ctrl_reg[`SCRS_B_RETRACT];
  assign manual_step_bit = ctrl_reg[`SCRS_B_STEP];
  assign power_disable_bit = ctrl_reg[`SCRS_B_PWRDIS];
  always_comb begin
    unique case ({ctrl_reg[`SCRS_B_RESET], ctrl_reg[`SCRS_B_ENABLE]})
      2'b11: mode = scrs_pkg::scrs_preset;
      2'b01: mode = scrs_pkg::scrs_start;
      2'b10: mode = scrs_pkg::scrs_brake;
      default: mode = power_disable_bit ? scrs_pkg::scrs_run :
                      scrs_pkg::scrs_coast;
    endcase
  end
  // Rising edge of the step bit is one host pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_last_reg <= 1'b0;
    end else begin
      step_last_reg <= manual_step_bit;
    end
  end
  assign com_clear = (mode == scrs_pkg::scrs_preset) ||
                     (mode == scrs_pkg::scrs_brake);
  assign com_step = (mode == scrs_pkg::scrs_start) ?
                    (manual_step_bit && !step_last_reg) :
                    (vco_s && !vco_last_reg);
  scrs_commutator u_com (
    .pclk(pclk),
    .presetn(presetn),
    .step(com_step),
    .clear(com_clear),
    .state(com_state),
    .hi_en(winding_hi_en),
    .lo_en(winding_lo_en),
    .sink_on_pos(sink_on_pos)
  );
  // ----------------------------------------------------------------
  // Phase error charge pump
  // ----------------------------------------------------------------
  // Comparator says undriven winding is above driven mean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_source <= 1'b0;
      pump_sink <= 1'b0;
      loop_filter_idle <= 1'b1;
    end else if (mode == scrs_pkg::scrs_run &&
                 com_state != scrs_pkg::scrs_com_rst) begin
      pump_source <= upos_s ^ sink_on_pos;
      pump_sink <= !(upos_s ^ sink_on_pos);
      loop_filter_idle <= 1'b0;
    end else begin
      pump_source <= 1'b0;
      pump_sink <= 1'b0;
      loop_filter_idle <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Retract sequencer
  // ----------------------------------------------------------------
  scrs_pkg::scrs_act_t act_reg; // Actuator operation
  logic [14:0] pre_reg; // Millisecond prescaler
  logic [7:0] ms_reg; // Elapsed ms in this level
  logic [7:0] bd_reg; // Elapsed ms since retract start
  logic brake_req_reg; // Retract brake delay expired
  logic brake_latch_reg; // Fault brake held until preset
  logic trig, ms_tick, rstart, lvl_done;
  assign trig = fault_s || host_retract_request;
  assign ms_tick = (pre_reg == 15'(MS_CYCLES - 1));
  assign rstart = trig && act_reg == scrs_pkg::scrs_act_linear;
  assign lvl_done =
    (act_reg == scrs_pkg::scrs_act_lvl1 &&
     ms_reg >= level_one_duration) ||
    (act_reg == scrs_pkg::scrs_act_lvl2 &&
     ms_reg >= level_two_duration);
  // Operation state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= scrs_pkg::scrs_act_linear;
    end else if (!trig) begin
      act_reg <= scrs_pkg::scrs_act_linear;
    end else begin
      unique case (act_reg)
        scrs_pkg::scrs_act_linear: act_reg <= scrs_pkg::scrs_act_lvl1;
        scrs_pkg::scrs_act_lvl1:
          if (lvl_done) act_reg <= scrs_pkg::scrs_act_lvl2;
        scrs_pkg::scrs_act_lvl2:
          if (lvl_done) act_reg <= scrs_pkg::scrs_act_float;
        scrs_pkg::scrs_act_float: act_reg <= scrs_pkg::scrs_act_float;
      endcase
    end
  end
  // Millisecond timebase, restarted at each level change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 15'h0000;
      ms_reg <= 8'h00;
    end else if (rstart || lvl_done || !trig) begin
      pre_reg <= 15'h0000;
      ms_reg <= 8'h00;
    end else if (ms_tick) begin
      pre_reg <= 15'h0000;
      ms_reg <= (ms_reg == 8'hff) ? ms_reg : ms_reg + 8'h01;
    end else begin
      pre_reg <= pre_reg + 15'h0001;
    end
  end
  // Brake delay counter runs from retract start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bd_reg <= 8'h00;
      brake_req_reg <= 1'b0;
    end else if (act_reg == scrs_pkg::scrs_act_linear) begin
      bd_reg <= 8'h00;
      brake_req_reg <= 1'b0;
    end else begin
      if (ms_tick && bd_reg != 8'hff) begin
        bd_reg <= bd_reg + 8'h01;
      end
      brake_req_reg <= bd_reg >= brake_delay_interval;
    end
  end
  // Brake from a power fault holds until preset, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_latch_reg <= 1'b0;
    end else if (brake_req_reg && fault_s) begin
      brake_latch_reg <= 1'b1;
    end else if (mode == scrs_pkg::scrs_preset) begin
      brake_latch_reg <= 1'b0;
    end
  end
  // Registered actuator and spindle outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_two_amp <= `SCRS_RST_AMP;
      spindle_brake <= 1'b0;
      sat_flag <= 1'b0;
    end else begin
      level_two_amp <= amp_reg;
      spindle_brake <= brake_req_reg || brake_latch_reg ||
                       mode == scrs_pkg::scrs_brake;
      sat_flag <= sat_s && act_reg == scrs_pkg::scrs_act_linear;
    end
  end
  assign act_linear = act_reg == scrs_pkg::scrs_act_linear;
  assign act_level_one = act_reg == scrs_pkg::scrs_act_lvl1;
  assign act_level_two = act_reg == scrs_pkg::scrs_act_lvl2;
  assign act_float = act_reg == scrs_pkg::scrs_act_float;
  // Events for the sticky status
  assign iev[`SCRS_I_RSTART] = rstart;
  assign iev[`SCRS_I_FLOAT] = lvl_done &&
                              act_reg == scrs_pkg::scrs_act_lvl2;
  assign iev[`SCRS_I_BRAKE] = brake_req_reg && !spindle_brake;
  assign iev[`SCRS_I_SAT] = sat_s && act_linear;
  assign iev[`SCRS_I_FAULT] = fault_s && !brake_latch_reg && rstart;
  // ----------------------------------------------------------------
  // Read data and error answer, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_en) begin
      pslverr <= !mapped;
      unique case (paddr)
        `SCRS_OFF_CTRL: prdata <= {27'h0, ctrl_reg};
        `SCRS_OFF_LVL1: prdata <= {24'h0, level_one_duration};
        `SCRS_OFF_LVL2: prdata <= {24'h0, level_two_duration};
        `SCRS_OFF_BDLY: prdata <= {24'h0, brake_delay_interval};
        `SCRS_OFF_AMP: prdata <= {29'h0, amp_reg};
        `SCRS_OFF_STAT: prdata <= {22'h0, sat_flag, spindle_brake,
                                   act_reg, com_state, mode};
        `SCRS_OFF_ISTAT: prdata <= {27'h0, istat_reg};
        `SCRS_OFF_IEN: prdata <= {27'h0, ien_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_in_lvl1;
    act_reg == scrs_pkg::scrs_act_lvl1;
  endsequence
  sequence s_to_lvl2;
    ##[1:2] act_reg == scrs_pkg::scrs_act_lvl2;
  endsequence
  property p_enter;
    @(posedge pclk) disable iff (!presetn)
      (fault_s && act_linear) |=> s_in_lvl1;
  endproperty
  a_enter: assert property (p_enter)
    else $error("fault did not start retract");
  property p_linear;
    @(posedge pclk) disable iff (!presetn)
      !trig |=> act_linear;
  endproperty
  a_linear: assert property (p_linear)
    else $error("actuator not linear without retract cause");
  property p_lvl12;
    @(posedge pclk) disable iff (!presetn)
      (s_in_lvl1 and (ms_reg >= level_one_duration) and trig) |->
      s_to_lvl2;
  endproperty
  a_lvl12: assert property (p_lvl12)
    else $error("level two did not follow level one");
  property p_float;
    @(posedge pclk) disable iff (!presetn)
      (act_level_two && lvl_done && trig) |=> act_float;
  endproperty
  a_float: assert property (p_float)
    else $error("actuator not floated after level two");
  property p_brake;
    @(posedge pclk) disable iff (!presetn)
      (!act_linear && $past(!act_linear) &&
       $past(bd_reg) >= brake_delay_interval &&
       $stable(brake_delay_interval)) |=> spindle_brake;
  endproperty
  a_brake: assert property (p_brake)
    else $error("spindle not braked after delay");
  property p_idle;
    @(posedge pclk) disable iff (!presetn)
      (mode != scrs_pkg::scrs_run) |=>
      (loop_filter_idle && !pump_source && !pump_sink);
  endproperty
  a_idle: assert property (p_idle)
    else $error("loop node not idle outside run");
  property p_pump;
    @(posedge pclk) disable iff (!presetn)
      (mode == scrs_pkg::scrs_run &&
       com_state == scrs_pkg::scrs_com_a && upos_s) |=>
      pump_source;
  endproperty
  a_pump: assert property (p_pump)
    else $error("state A positive did not source");
  property p_sat;
    @(posedge pclk) disable iff (!presetn)
      (sat_s && act_linear) |=> (sat_flag && istat_reg[`SCRS_I_SAT]);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation not flagged");
endmodule

// File: testbench/scrs_motor.sv
// Oscillator and back-EMF model on the far side of the commutator
`timescale 1ns/1ns
module scrs_motor (
  input wire logic pclk,
  input wire logic kick,
  input wire logic bemf_pos,
  output logic vco_pulse,
  output logic undriven_positive
);
  logic [1:0] hold_reg;
  initial hold_reg = 2'h0;
  // Each kick gives one oscillator pulse three cycles wide
  always @(posedge pclk) begin
    hold_reg <= kick ? 2'h3 : hold_reg - {1'b0, |hold_reg};
  end
  assign vco_pulse = |hold_reg;
  // Sign of the undriven winding against the driven mean
  assign undriven_positive = bemf_pos;
endmodule

// File: testbench/tb.sv
// Self-checking bench for the commutator and retract sequencer
`timescale 1ns/1ns
`include "scrs_cfg.svh"
module tb;
  localparam int MS = 4;
  logic pclk, presetn, psel, penable, pwrite, vf, kick, upos, sat, vco, updr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, l1, l2;
  logic pready, pslverr, er, pso, psi, idle, al, a1, a2, af, brk, satf, irq;
  logic [2:0] hi, lo, amp, lamp;
  logic [5:0] tbl [7] = '{6'h2a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22, 6'h0a};
  int errors, compares, cyc, n, k, seed;
  scrs_top #(.MS_CYCLES(MS)) u_scrs_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .voltage_fault(vf), .vco_pulse(vco), .undriven_positive(updr),
    .amp_saturated(sat), .winding_hi_en(hi), .winding_lo_en(lo),
    .pump_source(pso), .pump_sink(psi), .loop_filter_idle(idle),
    .act_linear(al), .act_level_one(a1), .act_level_two(a2),
    .act_float(af), .level_two_amp(lamp), .spindle_brake(brk),
    .sat_flag(satf), .irq(irq));
  scrs_motor u_scrs_motor (.pclk(pclk), .kick(kick), .bemf_pos(upos),
    .vco_pulse(vco), .undriven_positive(updr));
  // Expected pump pair: sink states B, D, F reverse the polarity
  function automatic logic [1:0] pump(int idx, logic pos);
    logic s;
    s = pos ^ (idx % 2 == 0);
    return {s, ~s};
  endfunction
  // Phase length in cycles matches the programmed count of ms
  function automatic logic in_win(int cnt, logic [31:0] ms);
    return cnt >= MS * ms - 1 && cnt <= MS * ms + 2;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task end_sim;
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, vf, kick, upos, sat} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h2e2b77b9;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({hi, lo}, tbl[0]);
    chk({al, a1, a2, af, brk, irq}, 6'h20);
    apb(1'b0, `SCRS_OFF_LVL1, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Start mode: each host step pulse moves one state, with wrap
    apb(1'b1, `SCRS_OFF_CTRL, 32'h3);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h1);
    for (k = 0; k < 7; k++) begin
      apb(1'b1, `SCRS_OFF_CTRL, 32'h9);
      apb(1'b1, `SCRS_OFF_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      chk({hi, lo}, tbl[k % 6 + 1]);
      chk({idle, pso, psi}, 3'h4);
    end
    // Preset returns to the reset state, then run on oscillator pulses
    apb(1'b1, `SCRS_OFF_CTRL, 32'h13);
    repeat (2) @(posedge pclk);
    chk({hi, lo}, tbl[0]);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h10);
    for (k = 0; k < 7; k++) begin
      upos <= 1'($random(seed));
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      repeat (10) @(posedge pclk);
      chk({hi, lo}, tbl[k % 6 + 1]);
      chk({idle, pso, psi}, {1'b0, pump(k % 6 + 1, upos)});
    end
    // Coast: commutator still follows the oscillator, loop node idles
    apb(1'b1, `SCRS_OFF_CTRL, 32'h0);
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({hi, lo}, tbl[2]);
    chk({idle, pso, psi}, 3'h4);
    sat <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(satf, 1'b1);
    sat <= 1'b0;
    // Host retract with programmed phases and amplitude
    l1 = 32'(($random(seed) & 3) + 1);
    l2 = 32'(($random(seed) & 3) + 1);
    amp = 3'($random(seed));
    apb(1'b1, `SCRS_OFF_LVL1, l1);
    apb(1'b1, `SCRS_OFF_LVL2, l2);
    apb(1'b1, `SCRS_OFF_BDLY, 32'h1);
    apb(1'b1, `SCRS_OFF_AMP, {29'h0, amp});
    apb(1'b1, `SCRS_OFF_IEN, 32'h1);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h14);
    for (n = 0; n < 6 && a1 !== 1'b1; n++) @(posedge pclk);
    chk({a1, brk}, 2'h2);
    for (n = 0; n < 60 && a1 === 1'b1; n++) @(posedge pclk);
    chk(in_win(n, l1), 1'b1);
    chk({a2, lamp}, {1'b1, amp});
    for (n = 0; n < 60 && a2 === 1'b1; n++) @(posedge pclk);
    chk(in_win(n, l2), 1'b1);
    chk({af, brk, irq}, 3'h7);
    apb(1'b1, `SCRS_OFF_IEN, 32'h0);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `SCRS_OFF_ICLR, 32'h1f);
    apb(1'b1, `SCRS_OFF_IEN, 32'h1f);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h10);
    repeat (4) @(posedge pclk);
    chk({al, brk}, 2'h2);
    // Supply fault: retract, brake latched until preset
    vf <= 1'b1;
    for (n = 0; n < 8 && a1 !== 1'b1; n++) @(posedge pclk);
    chk(a1, 1'b1);
    repeat (12) @(posedge pclk);
    vf <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({al, brk}, 2'h3);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    chk(brk, 1'b0);
    apb(1'b1, `SCRS_OFF_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    chk({hi, lo, idle, brk}, {tbl[0], 2'h3});
    end_sim;
  end
endmodule
